//--- hw/mfio_top.sv
// multifunction input decode, one-shot switching output, span teach and span/shift write
`timescale 1ns/1ps
`default_nettype none
module mfio_top (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // external multifunction input pin
  input  wire logic        MULTIFUNCTION_INPUT,
  // configuration
  input  wire logic        FACTORY_RESET,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_POL_LOW,
  input  wire logic [2:0]  CFG_FUNCTION,
  input  wire logic [14:0] CFG_DEBOUNCE_MS,
  input  wire logic [11:0] CFG_OFF_DELAY_MS,
  input  wire logic [6:0]  CFG_ON_DELAY_MS,
  input  wire logic        CFG_ONE_SHOT,
  input  wire logic [1:0]  HOLD_MODE,
  input  wire logic [15:0] REC_ENTRY_COUNT,
  // switching output condition and recording progress
  input  wire logic        OUT_COND,
  input  wire logic        REC_ENTRY_SAVED,
  // calibration
  input  wire logic [15:0] MEAS_VALUE,
  input  wire logic [15:0] REF_THICKNESS,
  input  wire logic        TEACH_THICK,
  input  wire logic        SPAN_WR,
  input  wire logic [15:0] SPAN_IN,
  input  wire logic        SHIFT_WR,
  input  wire logic [15:0] SHIFT_IN,
  // outputs
  output logic             SWITCH_OUT,
  output logic             LASER_OFF,
  output logic             HOLD_TRIGGER,
  output logic             HOLD_RESET,
  output logic             REC_ACTIVE,
  output logic             REC_CLOSE_FILE,
  output logic             OFFSET_APPLY,
  output logic             OFFSET_RELEASE,
  output logic             POL_LOW_STATE,
  output logic [2:0]       FUNCTION_STATE,
  output logic [15:0]      SPAN,
  output logic [15:0]      SHIFT
);

  function automatic logic [14:0] clamp15(input logic [14:0] v, input logic [14:0] m);
    clamp15 = (v > m) ? m : v;
  endfunction

  typedef enum logic [1:0] {OS_IDLE, OS_ON_WAIT, OS_PULSE, OS_DONE} mfio_os_t;

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic              pol_low_r;
  mfio_pkg::mfio_fn_t fn_r;
  logic [14:0]       deb_ms_r;
  logic [11:0]       off_ms_r;
  logic [6:0]        on_ms_r;
  wire  [14:0]       off_clamp = clamp15({3'h0, CFG_OFF_DELAY_MS}, {3'h0, mfio_pkg::OFF_DLY_MAX_MS});
  wire  [14:0]       on_clamp  = clamp15({8'h00, CFG_ON_DELAY_MS}, {8'h00, mfio_pkg::ON_DLY_MAX_MS});
  wire  [2:0]        fn_sel    = (CFG_FUNCTION > 3'(mfio_pkg::MFIO_FN_OFFSET)) ? 3'(mfio_pkg::MFIO_FN_NONE) : CFG_FUNCTION;

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pol_low_r <= mfio_pkg::POL_DEF;
      fn_r      <= mfio_pkg::FN_DEF;
      deb_ms_r  <= mfio_pkg::DEBOUNCE_DEF_MS;
      off_ms_r  <= mfio_pkg::OFF_DLY_DEF_MS;
      on_ms_r   <= mfio_pkg::ON_DLY_DEF_MS;
    end else if (FACTORY_RESET) begin
      pol_low_r <= mfio_pkg::POL_DEF;
      fn_r      <= mfio_pkg::FN_DEF;
      deb_ms_r  <= mfio_pkg::DEBOUNCE_DEF_MS;
      off_ms_r  <= mfio_pkg::OFF_DLY_DEF_MS;
      on_ms_r   <= mfio_pkg::ON_DLY_DEF_MS;
    end else if (CFG_WR) begin
      pol_low_r <= CFG_POL_LOW;
      fn_r      <= mfio_pkg::mfio_fn_t'(fn_sel);
      deb_ms_r  <= clamp15(CFG_DEBOUNCE_MS, mfio_pkg::DEBOUNCE_MAX_MS);
      off_ms_r  <= off_clamp[11:0];
      on_ms_r   <= on_clamp[6:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // millisecond tick
  logic [15:0] ms_cnt_r;
  wire         ms_tick = (ms_cnt_r == mfio_pkg::MS_CNT_MAX);

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) ms_cnt_r <= 16'h0000;
    else       ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser, debounce, polarity
  logic [2:0]  sync_r;
  logic        deb_r;
  logic [14:0] deb_cnt_r;
  wire         pin_lvl  = sync_r[2];
  wire         agree    = (sync_r[1] == sync_r[2]);
  wire         differs  = agree && (pin_lvl != deb_r);
  wire         deb_done = (deb_cnt_r >= deb_ms_r);

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) sync_r <= 3'h0;
    else       sync_r <= {sync_r[1:0], MULTIFUNCTION_INPUT};
  end

  // candidate level must hold for the debounce time before it is taken
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      deb_r     <= 1'b0;
      deb_cnt_r <= 15'h0000;
    end else begin
      if (!differs) deb_cnt_r <= 15'h0000;
      else if (deb_done) begin
        deb_r     <= pin_lvl;
        deb_cnt_r <= 15'h0000;
      end else if (ms_tick) deb_cnt_r <= deb_cnt_r + 15'h0001;
    end
  end

  wire in_act = deb_r ^ pol_low_r;
  logic in_act_d_r;
  wire  act_rise = in_act & ~in_act_d_r;
  wire  act_fall = ~in_act & in_act_d_r;

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) in_act_d_r <= 1'b0;
    else       in_act_d_r <= in_act;
  end

  //////////////////////////////////////////////////////////////////////////////
  // function decode
  wire is_emit = (fn_r == mfio_pkg::MFIO_FN_EMIT_OFF);
  wire is_hold = (fn_r == mfio_pkg::MFIO_FN_HOLD);
  wire is_rec  = (fn_r == mfio_pkg::MFIO_FN_REC);
  wire is_off  = (fn_r == mfio_pkg::MFIO_FN_OFFSET);
  wire auto_hold = (HOLD_MODE == mfio_pkg::MFIO_HOLD_AUTO_PEAK) || (HOLD_MODE == mfio_pkg::MFIO_HOLD_AUTO_BOTTOM);

  logic [15:0] rec_cnt_r;
  logic        rec_r;
  logic [10:0] press_ms_r;
  wire         rec_full  = (rec_cnt_r >= REC_ENTRY_COUNT);
  wire         rec_start = is_rec && act_rise && !rec_r;
  wire         rec_stop  = rec_r && (!is_rec || !in_act || (REC_ENTRY_SAVED && (rec_cnt_r + 16'h0001 >= REC_ENTRY_COUNT)));
  wire         press_long = (press_ms_r >= mfio_pkg::OFFSET_LONG_MS);

  // function none leaves the laser, hold and offset outputs idle and starts no recording
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      LASER_OFF      <= 1'b0;
      HOLD_TRIGGER   <= 1'b0;
      HOLD_RESET     <= 1'b0;
      OFFSET_APPLY   <= 1'b0;
      OFFSET_RELEASE <= 1'b0;
    end else begin
      LASER_OFF      <= is_emit && in_act;
      HOLD_TRIGGER   <= is_hold && act_rise && !auto_hold;
      HOLD_RESET     <= is_hold && act_rise && auto_hold;
      OFFSET_APPLY   <= is_off && act_fall && !press_long;
      OFFSET_RELEASE <= is_off && act_fall && press_long;
    end
  end

  // press timer saturates at the long-press threshold
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) press_ms_r <= 11'h000;
    else if (!in_act) press_ms_r <= 11'h000;
    else if (ms_tick && !press_long) press_ms_r <= press_ms_r + 11'h001;
  end

  // recording: stops on full count or on release, closing file either way
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      rec_r          <= 1'b0;
      rec_cnt_r      <= 16'h0000;
      REC_CLOSE_FILE <= 1'b0;
    end else begin
      REC_CLOSE_FILE <= rec_stop;
      if (rec_start && !rec_full) begin
        rec_r     <= 1'b1;
        rec_cnt_r <= 16'h0000;
      end else if (rec_stop) rec_r <= 1'b0;
      else if (rec_r && REC_ENTRY_SAVED) rec_cnt_r <= rec_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) REC_ACTIVE <= 1'b0;
    else       REC_ACTIVE <= rec_r && !rec_stop;
  end

  //////////////////////////////////////////////////////////////////////////////
  // switching output with on/off delay and one-shot
  mfio_os_t    os_r;
  logic [11:0] dly_ms_r;
  wire         on_done  = (dly_ms_r >= {5'h00, on_ms_r});
  wire         off_done = (dly_ms_r >= off_ms_r);

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      os_r       <= OS_IDLE;
      dly_ms_r   <= 12'h000;
      SWITCH_OUT <= 1'b0;
    end else begin
      case (os_r)
        OS_IDLE: begin
          dly_ms_r <= 12'h000;
          if (OUT_COND) os_r <= OS_ON_WAIT;
          else if (SWITCH_OUT) os_r <= OS_PULSE;
        end
        OS_ON_WAIT: begin
          if (!OUT_COND) begin
            os_r <= SWITCH_OUT ? OS_PULSE : OS_IDLE;
            dly_ms_r <= 12'h000;
          end else if (on_done) begin
            SWITCH_OUT <= 1'b1;
            dly_ms_r   <= 12'h000;
            os_r       <= CFG_ONE_SHOT ? OS_PULSE : OS_DONE;
          end else if (ms_tick) dly_ms_r <= dly_ms_r + 12'h001;
        end
        OS_PULSE: begin
          // off delay: pulse width in one-shot, hold time after condition drops otherwise
          if (!CFG_ONE_SHOT && OUT_COND) begin
            dly_ms_r <= 12'h000;
            os_r     <= OS_DONE;
          end else if (off_done) begin
            SWITCH_OUT <= 1'b0;
            dly_ms_r   <= 12'h000;
            os_r       <= (CFG_ONE_SHOT && OUT_COND) ? OS_DONE : OS_IDLE;
          end else if (ms_tick) dly_ms_r <= dly_ms_r + 12'h001;
        end
        OS_DONE: begin
          if (!OUT_COND) os_r <= (CFG_ONE_SHOT || !SWITCH_OUT) ? OS_IDLE : OS_PULSE;
        end
        default: os_r <= OS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // calibration: span = reference / measurement, in fixed point
  logic [31:0] quot_w;
  always_comb begin
    quot_w = 32'h0000_0000;
    if (MEAS_VALUE != 16'h0000) quot_w = ({16'h0000, REF_THICKNESS} << mfio_pkg::SPAN_FRAC) / {16'h0000, MEAS_VALUE};
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      SPAN  <= mfio_pkg::SPAN_ONE;
      SHIFT <= mfio_pkg::SHIFT_DEF;
    end else begin
      if (SPAN_WR) SPAN <= SPAN_IN;
      else if (TEACH_THICK && MEAS_VALUE != 16'h0000) SPAN <= quot_w[15:0];
      if (SHIFT_WR) SHIFT <= SHIFT_IN;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      POL_LOW_STATE  <= mfio_pkg::POL_DEF;
      FUNCTION_STATE <= 3'(mfio_pkg::FN_DEF);
    end else begin
      POL_LOW_STATE  <= pol_low_r;
      FUNCTION_STATE <= 3'(fn_r);
    end
  end

endmodule
`default_nettype wire

//--- hw/mfio_pkg.sv
// constants and types for the multifunction input and one-shot block
package mfio_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam logic [15:0] MS_CNT_MAX      = 16'(CYC_PER_MS - 1);
  localparam logic [14:0] DEBOUNCE_MAX_MS = 15'h7FFF;
  localparam logic [14:0] DEBOUNCE_DEF_MS = 15'h4E20;
  localparam logic [11:0] OFF_DLY_MAX_MS  = 12'hFA0;
  localparam logic [11:0] OFF_DLY_DEF_MS  = 12'h000;
  localparam logic [6:0]  ON_DLY_MAX_MS   = 7'h64;
  localparam logic [6:0]  ON_DLY_DEF_MS   = 7'h00;
  localparam int unsigned OFFSET_LONG_S   = 1;
  localparam logic [10:0] OFFSET_LONG_MS  = 11'(OFFSET_LONG_S * 1000);
  localparam logic        POL_HIGH        = 1'b0;
  localparam logic        POL_DEF         = POL_HIGH;
  localparam logic [15:0] SPAN_ONE        = 16'h4000;
  localparam logic [15:0] SHIFT_DEF       = 16'h0000;
  localparam int unsigned SPAN_FRAC       = 14;

  typedef enum logic [2:0] {
    MFIO_FN_NONE, MFIO_FN_EMIT_OFF, MFIO_FN_HOLD, MFIO_FN_REC, MFIO_FN_OFFSET
  } mfio_fn_t;

  typedef enum logic [1:0] {
    MFIO_HOLD_PEAK, MFIO_HOLD_BOTTOM, MFIO_HOLD_AUTO_PEAK, MFIO_HOLD_AUTO_BOTTOM
  } mfio_hold_t;

  localparam mfio_fn_t FN_DEF = MFIO_FN_NONE;
endpackage

//--- test/mfio_top_assertions.sv
// port checks for the multifunction input block
`timescale 1ns/1ps
`default_nettype none
module mfio_top_assertions (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RESET,
  // inputs
  input wire logic        FACTORY_RESET,
  input wire logic [1:0]  HOLD_MODE,
  input wire logic        SPAN_WR,
  input wire logic [15:0] SPAN_IN,
  input wire logic        OUT_COND,
  input wire logic        CFG_ONE_SHOT,
  // outputs
  input wire logic        SWITCH_OUT,
  input wire logic        LASER_OFF,
  input wire logic        HOLD_TRIGGER,
  input wire logic        HOLD_RESET,
  input wire logic        REC_ACTIVE,
  input wire logic        REC_CLOSE_FILE,
  input wire logic        OFFSET_APPLY,
  input wire logic        OFFSET_RELEASE,
  input wire logic        POL_LOW_STATE,
  input wire logic [2:0]  FUNCTION_STATE,
  input wire logic [15:0] SPAN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  property p_hold_trig; HOLD_TRIGGER |-> FUNCTION_STATE == 3'h2 && !$past(HOLD_MODE[1]); endproperty
  a_hold_trig: assert property (p_hold_trig) else $error("hold trigger in wrong mode");
  property p_hold_rst; HOLD_RESET |-> FUNCTION_STATE == 3'h2 && $past(HOLD_MODE[1]); endproperty
  a_hold_rst: assert property (p_hold_rst) else $error("hold reset in wrong mode");
  property p_hold_pulse; HOLD_TRIGGER || HOLD_RESET |=> !HOLD_TRIGGER && !HOLD_RESET; endproperty
  a_hold_pulse: assert property (p_hold_pulse) else $error("hold strobe too long");
  property p_laser; LASER_OFF |-> FUNCTION_STATE == 3'h1 || $past(FUNCTION_STATE) == 3'h1; endproperty
  a_laser: assert property (p_laser) else $error("laser off without function");
  property p_rec_close; REC_CLOSE_FILE |-> !REC_ACTIVE && $past(REC_ACTIVE); endproperty
  a_rec_close: assert property (p_rec_close) else $error("file closed out of order");
  property p_offset; OFFSET_APPLY || OFFSET_RELEASE |-> (OFFSET_APPLY ^ OFFSET_RELEASE) && FUNCTION_STATE == 3'h4;
  endproperty
  a_offset: assert property (p_offset) else $error("bad offset strobe");
  property p_span_wr; SPAN_WR |=> SPAN == $past(SPAN_IN); endproperty
  a_span_wr: assert property (p_span_wr) else $error("span write lost");
  property p_factory; FACTORY_RESET |-> ##2 (!POL_LOW_STATE && FUNCTION_STATE == 3'h0); endproperty
  a_factory: assert property (p_factory) else $error("factory defaults missing");
  property p_on_first; $rose(SWITCH_OUT) |-> $past(OUT_COND); endproperty
  a_on_first: assert property (p_on_first) else $error("output rose without condition");
  property p_one_shot; $fell(SWITCH_OUT) && $past(CFG_ONE_SHOT) && $past(OUT_COND) |=> !SWITCH_OUT; endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot output repeated");
  c_one_shot: cover property ($fell(SWITCH_OUT) && OUT_COND);
  c_hold: cover property (HOLD_RESET);
  c_rec: cover property (REC_CLOSE_FILE);
  c_offset: cover property (OFFSET_APPLY);
endmodule
bind mfio_top mfio_top_assertions u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .FACTORY_RESET(FACTORY_RESET),
  .HOLD_MODE(HOLD_MODE), .SPAN_WR(SPAN_WR), .SPAN_IN(SPAN_IN), .LASER_OFF(LASER_OFF), .HOLD_TRIGGER(HOLD_TRIGGER),
  .HOLD_RESET(HOLD_RESET), .REC_ACTIVE(REC_ACTIVE), .REC_CLOSE_FILE(REC_CLOSE_FILE), .OFFSET_APPLY(OFFSET_APPLY),
  .OFFSET_RELEASE(OFFSET_RELEASE), .POL_LOW_STATE(POL_LOW_STATE), .FUNCTION_STATE(FUNCTION_STATE), .SPAN(SPAN),
  .OUT_COND(OUT_COND), .CFG_ONE_SHOT(CFG_ONE_SHOT), .SWITCH_OUT(SWITCH_OUT));
`default_nettype wire

//--- test/mfio_plc.sv
// controller model driving the input pin and output condition
`timescale 1ns/1ps
`default_nettype none
module mfio_plc (
  // clock
  input wire logic clk,
  // driven lines
  output logic     pin,
  output logic     cond
);
  initial {pin, cond} = 2'b00;
  task automatic press(input int n);
    @(negedge clk) pin = 1'b1;
    repeat (n) @(negedge clk);
    pin = 1'b0;
  endtask
  task automatic drive(input logic p, input logic c);
    @(negedge clk) {pin, cond} = {p, c};
  endtask
endmodule
`default_nettype wire

//--- test/mfio_top_test.sv
// self-checking bench for the multifunction input block
`timescale 1ns/1ps
`default_nettype none
module mfio_top_test;
  logic        clk, rst, fr, cw, cp, os, sv, te, sw, hw, so, lo, ht, hr, ra, rcf, oa, orl, ps, swp;
  logic [1:0]  hm;
  logic [2:0]  cf, fs;
  logic [15:0] rc, me, rt, si, hi, sp, sh;
  logic [14:0] db;
  logic [11:0] od;
  logic [6:0]  ond;
  logic [5:0]  exp_q[$];
  int          n_fail, cmp_count;
  wire logic   pin, cond;
  wire logic [5:0] ev = {so & ~swp, ht, hr, rcf, oa, orl};
  mfio_plc plc (.clk(clk), .pin(pin), .cond(cond));
  mfio_top uut (.REF_CLK(clk), .RESET(rst), .MULTIFUNCTION_INPUT(pin), .FACTORY_RESET(fr), .CFG_WR(cw),
    .CFG_POL_LOW(cp), .CFG_FUNCTION(cf), .CFG_DEBOUNCE_MS(db), .CFG_OFF_DELAY_MS(od),
    .CFG_ON_DELAY_MS(ond), .CFG_ONE_SHOT(os), .HOLD_MODE(hm), .REC_ENTRY_COUNT(rc), .OUT_COND(cond),
    .REC_ENTRY_SAVED(sv), .MEAS_VALUE(me), .REF_THICKNESS(rt), .TEACH_THICK(te), .SPAN_WR(sw), .SPAN_IN(si),
    .SHIFT_WR(hw), .SHIFT_IN(hi), .SWITCH_OUT(so), .LASER_OFF(lo), .HOLD_TRIGGER(ht), .HOLD_RESET(hr),
    .REC_ACTIVE(ra), .REC_CLOSE_FILE(rcf), .OFFSET_APPLY(oa), .OFFSET_RELEASE(orl), .POL_LOW_STATE(ps),
    .FUNCTION_STATE(fs), .SPAN(sp), .SHIFT(sh));
  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic cfg(input logic p, input logic [2:0] f);
    {cp, cf} = {p, f};
    pulse(cw);
    wt(6);
  endtask
  task automatic drain;
    for (int i = 0; i < 50100 && exp_q.size() != 0; i++) @(negedge clk);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("CHECK FAILED events expected 0 seen %0d", exp_q.size());
      give_verdict();
    end
  endtask
  // event watcher: every strobe must match the oldest note
  always @(negedge clk) begin
    swp <= so;
    if (!rst && ev !== 6'h00) begin
      cmp_count++;
      if (exp_q.size() == 0 || ev !== exp_q[0]) begin
        n_fail++;
        $display("CHECK FAILED event expected %h seen %h", exp_q.size() ? exp_q[0] : 6'h00, ev);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {fr, cw, cp, os, sv, te, sw, hw, hm, cf, rc, me, rt, si, hi, db, od, ond} = '0;
    rst = 1'b1;
    void'($urandom(32'hF1FF2C69));
    wt(4);
    rst = 1'b0;
    wt(1);
    ck("pol", mfio_pkg::POL_DEF, ps);
    ck("fn", mfio_pkg::FN_DEF, fs);
    cfg(1'b0, 3'h2);
    for (int m = 0; m < 4; m++) begin
      hm = 2'(m);
      exp_q.push_back(m < 2 ? 6'h10 : 6'h08);
      plc.press(8 + $urandom % 16);
      drain();
      wt(8);
    end
    cfg(1'b0, 3'h0);
    plc.press(20);
    wt(10);
    cfg(1'b0, 3'h1);
    plc.drive(1'b1, 1'b0);
    wt(8);
    ck("laser", 1'b1, lo);
    plc.drive(1'b0, 1'b0);
    wt(8);
    ck("laser", 1'b0, lo);
    cfg(1'b1, 3'h1);
    ck("laser pol", 1'b1, lo);
    cfg(1'b0, 3'h0);
    cfg(1'b0, 3'h4);
    exp_q.push_back(6'h02);
    plc.press(8 + $urandom % 32);
    drain();
    cfg(1'b0, 3'h3);
    rc = 16'h0002;
    plc.drive(1'b1, 1'b0);
    wt(8);
    ck("rec", 1'b1, ra);
    exp_q.push_back(6'h04);
    pulse(sv);
    pulse(sv);
    drain();
    ck("rec", 1'b0, ra);
    plc.drive(1'b0, 1'b0);
    wt(8);
    plc.drive(1'b1, 1'b0);
    wt(8);
    exp_q.push_back(6'h04);
    pulse(sv);
    plc.drive(1'b0, 1'b0);
    drain();
    cfg(1'b0, 3'h0);
    os = 1'b1;
    exp_q.push_back(6'h20);
    plc.drive(1'b0, 1'b1);
    drain();
    wt(1);
    ck("pulse width", 1'b0, so);
    wt(20);
    ck("one shot", 1'b0, so);
    plc.drive(1'b0, 1'b0);
    ond = 7'h01;
    cfg(1'b0, 3'h0);
    exp_q.push_back(6'h20);
    plc.drive(1'b0, 1'b1);
    wt(2);
    ck("on delay", 1'b0, so);
    drain();
    plc.drive(1'b0, 1'b0);
    {me, rt} = {16'h2000, 16'h3000};
    pulse(te);
    wt(1);
    ck("span", 16'((32'(rt) << 14) / me), sp);
    rt = rt + 16'h1000;
    pulse(te);
    wt(1);
    ck("span two", 16'((32'(rt) << 14) / me), sp);
    {si, hi} = {16'($urandom), 16'($urandom)};
    @(negedge clk) {sw, hw} = 2'b11;
    @(negedge clk) {sw, hw} = 2'b00;
    ck("span", si, sp);
    ck("shift", hi, sh);
    plc.drive(1'b1, 1'b0);
    cfg(1'b1, 3'h0);
    cfg(1'b1, 3'h3);
    pulse(fr);
    wt(3);
    ck("pol", mfio_pkg::POL_DEF, ps);
    ck("fn", mfio_pkg::FN_DEF, fs);
    give_verdict();
  end
endmodule
`default_nettype wire
